// file: hw/ssd_pager_pkg.sv
// Shared constants, types and helpers for the socket bank pager and its host end
package ssd_pager_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int ADDR_W  = 20;                    // Host memory / I/O address
   localparam int BANK_W  = 7;                     // Bank field width
   localparam int OFS_W   = 13;                    // Offset inside one 8 KB bank
   localparam int NUM_SOCK = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Paging register map and layout
   localparam logic [15:0] BANK_REG_OFS = 16'h0000;
   localparam logic [15:0] SOCK_REG_OFS = 16'h0002;
   localparam int          WP_BIT       = 7;
   localparam int          SOCK_LSB     = 2;
   localparam logic [3:0]  SOCK_FIXED   = 4'h1;
   localparam logic [7:0]  BANK_RST     = 8'h00;
   localparam logic [1:0]  SOCK_RST     = 2'h0;
   localparam logic [7:0]  FLOAT_BYTE   = 8'hFF;   // Undriven bus reads high

   // Switch-selected I/O base for the paging registers
   function automatic logic [15:0] io_base_of(input logic [1:0] sw);
      unique case (sw)
         2'h0: io_base_of = 16'h0210;
         2'h1: io_base_of = 16'h0250;
         2'h2: io_base_of = 16'h0290;
         2'h3: io_base_of = 16'h0390;
      endcase
   endfunction : io_base_of

   // Switch-selected window, given as host address bits 19:13
   function automatic logic [6:0] win_base_of(input logic [1:0] sw);
      unique case (sw)
         2'h0: win_base_of = 7'h64;
         2'h1: win_base_of = 7'h68;
         2'h2: win_base_of = 7'h6C;
         2'h3: win_base_of = 7'h70;
      endcase
   endfunction : win_base_of

   ////////////////////////////////////////////////////////////////////////////
   // Link operations and fitted chip kinds
   typedef enum logic [1:0] {
      OP_IO_WR  = 2'h0,
      OP_IO_RD  = 2'h1,
      OP_MEM_WR = 2'h2,
      OP_MEM_RD = 2'h3
   } bus_op_type;

   typedef enum logic [2:0] {
      CHIP_ROM64  = 3'h0,
      CHIP_ROM128 = 3'h1,
      CHIP_ROM256 = 3'h2,
      CHIP_ROM512 = 3'h3,
      CHIP_ROM1M  = 3'h4,
      CHIP_RAM128 = 3'h5,
      CHIP_RAM512 = 3'h6
   } chip_type;

   // Places a bank number into the bank field for the fitted chip kind
   function automatic logic [6:0] compose_bank(input logic [2:0] chip, input logic [6:0] bank);
      unique case (chip)
         CHIP_ROM64:  compose_bank = {4'h2, bank[2:0]};
         CHIP_ROM128: compose_bank = {3'h0, bank[3:0]};
         CHIP_ROM256: compose_bank = {1'b0, bank[4], 1'b1, bank[3:0]};
         CHIP_ROM512: compose_bank = {1'b0, bank[4], bank[5], bank[3:0]};
         CHIP_ROM1M:  compose_bank = {bank[6], bank[4], bank[5], bank[3:0]};
         CHIP_RAM128: compose_bank = {3'h2, bank[3:0]};
         CHIP_RAM512: compose_bank = {1'b0, bank[5:0]};
         default:     compose_bank = 7'h00;
      endcase
   endfunction : compose_bank

   ////////////////////////////////////////////////////////////////////////////
   // Host command registers on APB
   localparam int          APB_AW      = 12;
   localparam logic [11:0] HR_ADDR     = 12'h000;
   localparam logic [11:0] HR_WDATA    = 12'h004;
   localparam logic [11:0] HR_CTRL     = 12'h008;
   localparam logic [11:0] HR_STAT     = 12'h00C;
   localparam logic [11:0] HR_PAGE     = 12'h010;
   localparam logic [11:0] HR_BASE     = 12'h014;
   localparam int          CTRL_GO     = 4;
   localparam int          STAT_BUSY   = 0;
   localparam int          STAT_RD_LSB = 8;
   localparam int          PAGE_BANK_LSB = 8;
   localparam int          PAGE_WP     = 15;
   localparam logic [15:0] HOST_BASE_RST = 16'h0210;

endpackage : ssd_pager_pkg

// file: hw/ssd_link_if.sv
// Host I/O and memory bus between the host end and the socket bank pager
`timescale 1ns/1ns
`default_nettype none
interface ssd_link_if;
   logic        io_wr;    // I/O write strobe
   logic        io_rd;    // I/O read strobe
   logic        mem_wr;   // Memory write strobe
   logic        mem_rd;   // Memory read strobe
   logic [19:0] addr;     // Address, I/O uses bits 15:0
   logic [7:0]  wdata;    // Write data
   logic        ack;      // Cycle done pulse
   logic [7:0]  rdata;    // Read data, valid with ack

   modport dev  (input io_wr, io_rd, mem_wr, mem_rd, addr, wdata, output ack, rdata);
   modport host (output io_wr, io_rd, mem_wr, mem_rd, addr, wdata, input ack, rdata);
endinterface : ssd_link_if
`default_nettype wire

// file: hw/ssd_socket_bank_pager.sv
// Device end: paging registers and socket access through the 8 KB window
//
// Design decision made in the host end: the APB register port.
`timescale 1ns/1ns
`default_nettype none

//
// Contract
// RL1: Memory seen as 8 KB banks, one visible.
// RL2: Bank numbers start at zero per socket.
// RL3: Switches pick the paging register I/O base.
// RL4: Switches pick the memory window location.
// RL5: Bank register base+0, socket register base+2.
// RL6: Bank register bit 7 enables write protect.
// RL7: Bank register bits 6:0 form bank field.
// RL8: Socket register: 0001, socket code, ignored bits.
// RL9: Software composes small EPROM bank fields.
// RL10: Large EPROM fields use scrambled bank bits.
// RL11: SRAM bank fields have their own layouts.
// RL12: Software sizes bank number to chip.
// RL13: Window cycles reach socket; protect blocks writes.
module ssd_socket_bank_pager (
   input  wire logic        pclk,                 // Bus clock
   input  wire logic        presetn,              // Async reset, active low
   ssd_link_if.dev          link,                 // Host bus
   input  wire logic [1:0]  io_base_switches,     // I/O base select
   input  wire logic [1:0]  window_base_switches, // Window select
   output logic      [19:0] sock_addr,            // Socket address
   output logic      [2:0]  sock_ce,              // Socket enables, one hot
   output logic             sock_oe,              // Socket read enable
   output logic             sock_we,              // Socket write enable
   output logic      [7:0]  sock_wdata,           // Socket write data
   input  wire logic [7:0]  sock_rdata,           // Socket read data
   output logic             write_protect_on,     // Protect state
   output logic      [1:0]  socket_code           // Selected socket
);
   import ssd_pager_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_ACCESS = 2'b10
   } pager_state_type;

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   pager_state_type state_r;
   logic [7:0]      bank_page_select_r;
   logic [1:0]      socket_code_r;
   bus_op_type      op_r;
   logic            hit_bank_r;
   logic            hit_sock_r;
   logic            hit_mem_r;
   logic            ack_r;
   logic [7:0]      rdata_r;

   logic            req;
   bus_op_type      op_nxt;
   logic [15:0]     io_base;
   logic            io_space;
   logic            hit_bank;
   logic            hit_sock;
   logic            hit_mem;
   logic            is_io;
   logic [6:0]      bank_field;
   logic            socket_code_hi;
   logic            socket_code_lo;

   assign bank_field     = bank_page_select_r[BANK_W-1:0];   // RL7
   assign socket_code_hi = socket_code_r[1];
   assign socket_code_lo = socket_code_r[0];

   assign req      = link.io_wr | link.io_rd | link.mem_wr | link.mem_rd;
   assign io_base  = io_base_of(io_base_switches);                 // RL3
   assign io_space = (link.addr[ADDR_W-1:16] == 4'h0);
   assign hit_bank = io_space && (link.addr[15:0] == io_base + BANK_REG_OFS);  // RL5
   assign hit_sock = io_space && (link.addr[15:0] == io_base + SOCK_REG_OFS);  // RL5
   // No socket selected means the window is not claimed at all
   assign hit_mem  = (link.addr[ADDR_W-1:OFS_W] == win_base_of(window_base_switches))
                     && (socket_code_hi | socket_code_lo);          // RL4 RL13
   assign is_io    = (op_nxt == OP_IO_WR) || (op_nxt == OP_IO_RD);

   // Two strobes at once are illegal; the fixed priority only keeps it defined
   always_comb begin
      if (link.io_wr) begin
         op_nxt = OP_IO_WR;
      end else if (link.io_rd) begin
         op_nxt = OP_IO_RD;
      end else if (link.mem_wr) begin
         op_nxt = OP_MEM_WR;
      end else begin
         op_nxt = OP_MEM_RD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing: one access cycle, then the answer

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (req) begin
                  state_r <= ST_ACCESS;
               end
            end
            ST_ACCESS: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_r       <= OP_IO_WR;
         hit_bank_r <= 1'b0;
         hit_sock_r <= 1'b0;
         hit_mem_r  <= 1'b0;
      end else if (state_r == ST_IDLE && req) begin
         op_r       <= op_nxt;
         hit_bank_r <= is_io && hit_bank;
         hit_sock_r <= is_io && hit_sock;
         hit_mem_r  <= !is_io && hit_mem;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Paging registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_page_select_r <= BANK_RST;
      end else if (state_r == ST_IDLE && op_nxt == OP_IO_WR && link.io_wr && hit_bank) begin
         bank_page_select_r <= link.wdata;                         // RL6 RL7
      end
   end

   // Upper bits are fixed and the two low bits are don't care
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         socket_code_r <= SOCK_RST;
      end else if (state_r == ST_IDLE && op_nxt == OP_IO_WR && link.io_wr && hit_sock) begin
         socket_code_r <= link.wdata[SOCK_LSB+1:SOCK_LSB];         // RL8
      end
   end

   assign write_protect_on = bank_page_select_r[WP_BIT];
   assign socket_code      = socket_code_r;

   ////////////////////////////////////////////////////////////////////////////
   // Socket side: strobes during the access cycle only, address and write data held after

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sock_addr  <= 20'h00000;
         sock_wdata <= 8'h00;
         sock_oe    <= 1'b0;
         sock_we    <= 1'b0;
      end else if (state_r == ST_IDLE && req && !is_io && hit_mem) begin
         // Bank field drives the chip lines above the 8 KB offset as is
         sock_addr  <= {bank_field, link.addr[OFS_W-1:0]};        // RL1 RL2 RL10 RL11
         sock_wdata <= link.wdata;
         sock_oe    <= (op_nxt == OP_MEM_RD);
         sock_we    <= (op_nxt == OP_MEM_WR) && !write_protect_on; // RL13
      end else begin
         sock_oe <= 1'b0;
         sock_we <= 1'b0;
      end
   end

   // One enable per socket, code 1..3 selects socket one..three
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SOCK; gi++) begin : g_sock
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sock_ce[gi] <= 1'b0;
            end else begin
               sock_ce[gi] <= (state_r == ST_IDLE) && req && !is_io && hit_mem
                              && (socket_code_r == 2'(gi + 1));  // RL13
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Answer

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (state_r == ST_ACCESS);
      end
   end

   // Unclaimed reads return the floating bus value so the host never hangs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= 8'h00;
      end else if (state_r == ST_ACCESS) begin
         if (op_r == OP_MEM_RD && hit_mem_r) begin
            rdata_r <= sock_rdata;                                 // RL13
         end else if (op_r == OP_IO_RD && hit_bank_r) begin
            rdata_r <= bank_page_select_r;                         // RL5
         end else if (op_r == OP_IO_RD && hit_sock_r) begin
            rdata_r <= {SOCK_FIXED, socket_code_r, 2'h0};          // RL8
         end else begin
            rdata_r <= FLOAT_BYTE;
         end
      end
   end

   assign link.ack   = ack_r;
   assign link.rdata = rdata_r;

endmodule : ssd_socket_bank_pager
`default_nettype wire

// file: hw/ssd_host_end.sv
// Host end: APB command registers that run cycles on the pager bus
`timescale 1ns/1ns
`default_nettype none
module ssd_host_end (
   input  wire logic                       pclk,     // Bus clock
   input  wire logic                       presetn,  // Async reset, active low
   input  wire logic                       psel,     // APB select
   input  wire logic                       penable,  // APB enable
   input  wire logic                       pwrite,   // APB direction
   input  wire logic [ssd_pager_pkg::APB_AW-1:0] paddr, // APB address
   input  wire logic [31:0]                pwdata,   // APB write data
   output logic      [31:0]                prdata,   // APB read data
   output logic                            pready,   // APB ready
   output logic                            pslverr,  // APB error
   ssd_link_if.host                        link      // Pager bus
);
   import ssd_pager_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE  = 3'b001,
      H_ISSUE = 3'b010,
      H_WAIT  = 3'b100
   } host_state_type;

   host_state_type state_r;
   logic [19:0]    addr_r;
   logic [7:0]     wdata_r;
   logic [15:0]    base_r;
   bus_op_type     op_r;
   logic [19:0]    cmd_addr_r;
   logic [7:0]     cmd_wdata_r;
   logic [7:0]     result_r;
   logic [31:0]    prdata_r;

   logic           setup;
   logic           wr_acc;
   logic           mapped;
   logic           busy;
   logic           go_cmd;
   logic           go_page;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait; read data is caught in the setup cycle

   assign setup   = psel && !penable;
   assign wr_acc  = psel && penable && pwrite;
   assign mapped  = (paddr == HR_ADDR) || (paddr == HR_WDATA) || (paddr == HR_CTRL)
                    || (paddr == HR_STAT) || (paddr == HR_PAGE) || (paddr == HR_BASE);
   assign busy    = (state_r != H_IDLE);
   // A new command while one is running is dropped
   assign go_cmd  = wr_acc && paddr == HR_CTRL && pwdata[CTRL_GO] && !busy;
   assign go_page = wr_acc && paddr == HR_PAGE && !busy;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (setup && !pwrite) begin
         unique case (paddr)
            HR_ADDR:  prdata_r <= {12'h000, addr_r};
            HR_WDATA: prdata_r <= {24'h000000, wdata_r};
            HR_CTRL:  prdata_r <= {30'h00000000, op_r};
            HR_STAT:  prdata_r <= {16'h0000, result_r, 7'h00, busy};
            HR_BASE:  prdata_r <= {16'h0000, base_r};
            default:  prdata_r <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r  <= 20'h00000;
         wdata_r <= 8'h00;
         base_r  <= HOST_BASE_RST;
      end else if (wr_acc) begin
         if (paddr == HR_ADDR) begin
            addr_r <= pwdata[19:0];
         end
         if (paddr == HR_WDATA) begin
            wdata_r <= pwdata[7:0];
         end
         if (paddr == HR_BASE) begin
            base_r <= pwdata[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command capture; a page write composes the bank byte for the chip kind

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_r        <= OP_IO_WR;
         cmd_addr_r  <= 20'h00000;
         cmd_wdata_r <= 8'h00;
      end else if (go_page) begin
         op_r        <= OP_IO_WR;
         cmd_addr_r  <= {4'h0, base_r + BANK_REG_OFS};               // RL5
         cmd_wdata_r <= {pwdata[PAGE_WP],
                         compose_bank(pwdata[2:0],
                                      pwdata[PAGE_BANK_LSB+BANK_W-1:PAGE_BANK_LSB])}; // RL9 RL10 RL11 RL12
      end else if (go_cmd) begin
         op_r        <= bus_op_type'(pwdata[1:0]);
         cmd_addr_r  <= addr_r;
         cmd_wdata_r <= wdata_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link sequencing: one strobe cycle, then wait for the answer

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= H_IDLE;
      end else begin
         unique case (state_r)
            H_IDLE: begin
               if (go_cmd || go_page) begin
                  state_r <= H_ISSUE;
               end
            end
            H_ISSUE: begin
               state_r <= H_WAIT;
            end
            H_WAIT: begin
               if (link.ack) begin
                  state_r <= H_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_r <= 8'h00;
      end else if (state_r == H_WAIT && link.ack) begin
         result_r <= link.rdata;
      end
   end

   assign link.io_wr  = (state_r == H_ISSUE) && (op_r == OP_IO_WR);
   assign link.io_rd  = (state_r == H_ISSUE) && (op_r == OP_IO_RD);
   assign link.mem_wr = (state_r == H_ISSUE) && (op_r == OP_MEM_WR);
   assign link.mem_rd = (state_r == H_ISSUE) && (op_r == OP_MEM_RD);
   assign link.addr   = cmd_addr_r;
   assign link.wdata  = cmd_wdata_r;

endmodule : ssd_host_end
`default_nettype wire

// file: testbench/ssd_pager_assertions.sv
// Checker for the pager bus and socket pins
`timescale 1ns/1ns
`default_nettype none
module ssd_pager_assertions (
   input wire logic        pclk,                 // Clock
   input wire logic        presetn,              // Reset, active low
   input wire logic        io_wr,                // I/O write
   input wire logic        io_rd,                // I/O read
   input wire logic        mem_wr,               // Memory write
   input wire logic        mem_rd,               // Memory read
   input wire logic [19:0] addr,                 // Address
   input wire logic [7:0]  wdata,                // Write data
   input wire logic        ack,                  // Done pulse
   input wire logic [7:0]  rdata,                // Read data
   input wire logic [1:0]  io_base_switches,     // I/O base select
   input wire logic [1:0]  window_base_switches, // Window select
   input wire logic [19:0] sock_addr,            // Socket address
   input wire logic [2:0]  sock_ce,              // Socket enables
   input wire logic        sock_oe,              // Socket read enable
   input wire logic        sock_we,              // Socket write enable
   input wire logic [7:0]  sock_rdata,           // Socket read data
   input wire logic        write_protect_on,     // Protect state
   input wire logic [1:0]  socket_code           // Selected socket
);
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [15:0] IO_T [4] = '{16'h0210, 16'h0250, 16'h0290, 16'h0390};
   localparam logic [6:0]  WIN_T [4] = '{7'h64, 7'h68, 7'h6C, 7'h70};
   logic [15:0] base;
   logic [6:0]  bank_r;
   logic        io_b0, io_b2, mem_s, hit;
   assign base  = IO_T[io_base_switches];
   assign io_b0 = io_wr && addr == {4'h0, base};
   assign io_b2 = addr == {4'h0, base + 16'h0002};
   assign mem_s = mem_rd || mem_wr;
   assign hit   = mem_s && addr[19:13] == WIN_T[window_base_switches] && socket_code != 2'h0;
   // Bank field shadow, as the pager has no port for it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bank_r <= 7'h00;
      else if (io_b0) bank_r <= wdata[6:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ack; (io_wr || io_rd || mem_s) |-> ##2 ack; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_rd; hit && mem_rd |-> ##2 (ack && rdata == $past(sock_rdata)); endproperty
   a_rd: assert property (p_rd) else $error("bad window read");
   property p_sa; hit |=> sock_addr == {bank_r, $past(addr[12:0])}
      && {sock_oe, sock_we} == $past({mem_rd, mem_wr && !write_protect_on}); endproperty
   a_sa: assert property (p_sa) else $error("socket address wrong");
   property p_ce; hit |=> sock_ce == 3'b001 << ($past(socket_code) - 2'h1); endproperty
   a_ce: assert property (p_ce) else $error("wrong socket enabled");
   property p_off; mem_s && !hit |=> (sock_ce == 3'h0 && !sock_we && !sock_oe); endproperty
   a_off: assert property (p_off) else $error("socket pins moved");
   property p_wpb; mem_wr && write_protect_on |=> !sock_we; endproperty
   a_wpb: assert property (p_wpb) else $error("protected write passed");
   property p_wp; io_b0 |=> write_protect_on == $past(wdata[7]); endproperty
   a_wp: assert property (p_wp) else $error("protect bit lost");
   property p_code; io_wr && io_b2 |=> socket_code == $past(wdata[3:2]); endproperty
   a_code: assert property (p_code) else $error("socket code lost");
   property p_srd; io_rd && io_b2 |-> ##2 rdata == {4'h1, $past(socket_code, 2), 2'h0}; endproperty
   a_srd: assert property (p_srd) else $error("socket read wrong");
   c_rd: cover property (hit && mem_rd);
   c_wr: cover property (hit && mem_wr && !write_protect_on);
   c_wpb: cover property (hit && mem_wr && write_protect_on);
endmodule : ssd_pager_assertions
`default_nettype wire

// file: testbench/ssd_socket_bank_pager_test.sv
// Bench: APB host end driving the socket bank pager
`timescale 1ns/1ns
`default_nettype none
module ssd_socket_bank_pager_test;
   import ssd_pager_pkg::*;
   localparam logic [15:0] IO_T [4] = '{16'h0210, 16'h0250, 16'h0290, 16'h0390};
   localparam logic [6:0]  WIN_T [4] = '{7'h64, 7'h68, 7'h6C, 7'h70};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_v, b, c;
   logic [1:0]  io_sw, win_sw, sock_code;
   logic [7:0]  sock_rdata, sock_wdata;
   logic [19:0] sock_addr, a_v;
   logic [2:0]  sock_ce;
   logic        sock_oe, sock_we, wp_on;
   logic [8:0]  q[$];
   logic [8:0]  note;
   int          n_mismatch, checks, s, k;
   ssd_link_if link();
   ssd_socket_bank_pager u_ssd_socket_bank_pager (.pclk(pclk), .presetn(presetn), .link(link),
      .io_base_switches(io_sw), .window_base_switches(win_sw), .sock_addr(sock_addr), .sock_ce(sock_ce),
      .sock_oe(sock_oe), .sock_we(sock_we), .sock_wdata(sock_wdata), .sock_rdata(sock_rdata),
      .write_protect_on(wp_on), .socket_code(sock_code));
   ssd_host_end u_ssd_host_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link(link));
   ssd_pager_assertions u_ssd_pager_assertions (.pclk(pclk), .presetn(presetn), .io_wr(link.io_wr),
      .io_rd(link.io_rd), .mem_wr(link.mem_wr), .mem_rd(link.mem_rd), .addr(link.addr), .wdata(link.wdata),
      .ack(link.ack), .rdata(link.rdata), .io_base_switches(io_sw), .window_base_switches(win_sw),
      .sock_addr(sock_addr), .sock_ce(sock_ce), .sock_oe(sock_oe), .sock_we(sock_we),
      .sock_rdata(sock_rdata), .write_protect_on(wp_on), .socket_code(sock_code));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic wrap_up;
      if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task automatic bust;
      n_mismatch++;
      $display("Error %0t: timeout", $time);
      wrap_up();
   endtask : bust
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int j;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (j = 0; j < 20; j++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (j == 20) bust();
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Host drops commands while busy, so each waits here
   task automatic idle;
      int j;
      for (j = 0; j < 40; j++) begin
         apb(1'b0, HR_STAT, 32'h0);
         if (rd_v[STAT_BUSY] === 1'b0) break;
      end
      if (j == 40) bust();
   endtask : idle
   task automatic cmd(input bus_op_type op, input logic [19:0] a, input logic [7:0] d, input logic [8:0] n);
      q.push_back(n);
      apb(1'b1, HR_ADDR, {12'h0, a});
      apb(1'b1, HR_WDATA, {24'h0, d});
      apb(1'b1, HR_CTRL, {27'h0, 1'b1, 2'h0, op});
      idle();
   endtask : cmd
   task automatic page(input logic [2:0] ch, input logic [6:0] bk, input logic wp);
      q.push_back(9'h000);
      apb(1'b1, HR_PAGE, {16'h0, wp, bk, 5'h0, ch});
      idle();
   endtask : page
   function automatic logic [6:0] exp_bank(input logic [2:0] ch, input logic [6:0] n);
      case (ch)
         3'h0: exp_bank = {4'h2, n[2:0]};
         3'h1: exp_bank = {3'h0, n[3:0]};
         3'h2: exp_bank = {1'b0, n[4], 1'b1, n[3:0]};
         3'h3: exp_bank = {1'b0, n[4], n[5], n[3:0]};
         3'h4: exp_bank = {n[6], n[4], n[5], n[3:0]};
         3'h5: exp_bank = {3'h2, n[3:0]};
         default: exp_bank = {1'b0, n[5:0]};
      endcase
   endfunction : exp_bank
   ////////////////////////////////////////////////////////////////////////////
   // Each ack retires the oldest note
   always @(posedge pclk) begin
      if (link.ack === 1'b1) begin
         if (q.size() == 0) begin
            n_mismatch++;
            $display("Error %0t: stray ack", $time);
         end else begin
            note = q.pop_front();
            if (note[8]) begin
               checks++;
               if (link.rdata !== note[7:0]) begin
                  n_mismatch++;
                  $display("Error %0t: read %h expected %h", $time, link.rdata, note[7:0]);
               end
            end
         end
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {io_sw, win_sw, sock_rdata} = '0;
      n_mismatch = 0;
      checks = 0;
      b = $urandom(32'h2115);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, HR_BASE, 32'h0);
      chk(rd_v, 32'h0000_0210);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err_v}, 32'h1);
      cmd(OP_IO_RD, 20'h00212, 8'h00, {1'b1, 8'h10});
      for (s = 0; s < 4; s++) begin
         io_sw <= s[1:0];
         apb(1'b1, HR_BASE, {16'h0, IO_T[s]});
         c = $urandom;
         cmd(OP_IO_WR, {4'h0, IO_T[s] + 16'h0002}, {4'h1, c[1:0], 2'h3}, 9'h000);
         cmd(OP_IO_RD, {4'h0, IO_T[s] + 16'h0002}, 8'h00, {1'b1, 4'h1, c[1:0], 2'h0});
         chk({30'h0, sock_code}, {30'h0, c[1:0]});
      end
      cmd(OP_IO_RD, 20'h00210, 8'h00, {1'b1, 8'hFF});
      for (k = 0; k < 7; k++) begin
         b = $urandom;
         page(k[2:0], b[6:0], k[0]);
         cmd(OP_IO_RD, 20'h00390, 8'h00, {1'b1, k[0], exp_bank(k[2:0], b[6:0])});
         chk({31'h0, wp_on}, {31'h0, k[0]});
      end
      for (s = 0; s < 4; s++) begin
         win_sw <= s[1:0];
         cmd(OP_IO_WR, 20'h00392, {4'h1, s[1:0], 2'h0}, 9'h000);
         b = $urandom;
         page(3'h4, b[6:0], 1'b0);
         sock_rdata <= b[14:7];
         a_v = {WIN_T[s], b[27:15]};
         cmd(OP_MEM_RD, a_v, 8'h00, {1'b1, (s == 0) ? 8'hFF : b[14:7]});
         cmd(OP_MEM_WR, a_v, b[7:0], 9'h000);
         chk({24'h0, sock_wdata}, {24'h0, s ? b[7:0] : 8'h0});
         page(3'h4, b[6:0], 1'b1);
         cmd(OP_MEM_WR, a_v, b[7:0], 9'h000);
         cmd(OP_MEM_RD, a_v ^ 20'h80000, 8'h00, {1'b1, 8'hFF});
      end
      wrap_up();
   end
endmodule : ssd_socket_bank_pager_test
`default_nettype wire
